// [hw/cmm_decode.sv]
// Core memory map: program counter, program store, banked data file decode.
// Assumes the core drives fetch control and operand requests on core_clk_i,
// and software reaches the same data file over APB.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module cmm_decode (
	// Clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     rst_b_i,
	// Core fetch side
	input  wire cmm_pkg::cmm_fetch_ctl_s  fetch_ctl_i,
	output logic [cmm_pkg::PROG_AW-1:0]   prog_addr_o,
	output logic [cmm_pkg::INSTR_W-1:0]   instr_o,
	// Core operand side
	input  wire cmm_pkg::cmm_opr_req_s    opr_req_i,
	input  wire logic                     alu_flags_we_i,
	input  wire logic [2:0]               alu_flags_i,
	output cmm_pkg::cmm_opr_rsp_s         opr_rsp_o,
	output logic [cmm_pkg::DATA_W-1:0]    flags_o,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [cmm_pkg::APB_AW-1:0] paddr,
	input  wire logic [cmm_pkg::APB_DW-1:0] pwdata,
	output logic [cmm_pkg::APB_DW-1:0]    prdata,
	output logic                          pready,
	output logic                          pslverr
);
	import cmm_pkg::*;

	logic [PC_W-1:0]     pc_r;
	logic [DATA_W-1:0]   flags_r;
	logic [DATA_W-1:0]   fptr_r;
	logic [LATCH_W-1:0]  pc_latch_r;
	logic [PROG_AW-1:0]  load_addr_r;
	logic                bank_fault_r;
	logic [INSTR_W-1:0]  prog_mem [PROG_DEPTH];
	logic [DATA_W-1:0]   ram      [RAM_DEPTH];

	logic                apb_acc;
	logic                apb_dfile;
	logic                apb_go;
	logic                apb_reg_go;
	logic                acc_go;
	cmm_acc_s            acc;
	logic [1:0]          eff_bank;
	logic [OFF_W-1:0]    eff_off;
	cmm_loc_e            loc;
	logic [RAM_AW-1:0]   ram_idx;
	logic                bank_absent;
	logic [DATA_W-1:0]   rd_val;
	logic                acc_wr;

	// Access arbitration
	// APB data-file accesses wait a cycle whenever the core uses the data path, so the core never stalls.
	assign apb_acc    = psel & penable & ~pready;
	assign apb_dfile  = ~paddr[APB_DFILE_BIT] & ~paddr[APB_DFILE_BIT+1];
	assign apb_go     = apb_acc & apb_dfile & ~opr_req_i.req;
	assign apb_reg_go = apb_acc & ~apb_dfile;
	assign acc_go     = opr_req_i.req | apb_go;
	assign acc_wr     = acc_go & acc.wr;

	always_comb begin
		if (opr_req_i.req) begin
			acc.wr    = opr_req_i.wr;
			acc.bank  = {flags_r[FLG_BANK_HI], flags_r[FLG_BANK_LO]};
			acc.off   = opr_req_i.addr;
			acc.wdata = opr_req_i.wdata;
		end else begin
			acc.wr    = pwrite;
			acc.bank  = {1'b0, paddr[APB_BANK_BIT]};
			acc.off   = paddr[OFF_W+1:2];
			acc.wdata = pwdata[DATA_W-1:0];
		end
	end

	always_comb begin
		if (acc.off == OFF_INDIRECT) begin
			eff_bank = {1'b0, fptr_r[FPTR_BANK_BIT]};
			eff_off  = fptr_r[OFF_W-1:0];
		end else begin
			eff_bank = acc.bank;
			eff_off  = acc.off;
		end
	end

	always_comb begin
		loc         = LOC_NONE;
		ram_idx     = eff_off - OFF_RAM_BASE;
		bank_absent = 1'b0;
		if (eff_off == OFF_INDIRECT) begin
			loc = LOC_NONE;
		end else if (eff_off == OFF_PC_LOW) begin
			loc = LOC_PC_LOW;
		end else if (eff_off == OFF_FLAGS) begin
			loc = LOC_FLAGS;
		end else if (eff_off == OFF_FPTR) begin
			loc = LOC_FPTR;
		end else if (eff_off == OFF_PC_LATCH) begin
			loc = LOC_PC_LATCH;
		end else if (eff_bank[1]) begin
			bank_absent = 1'b1;
		end else if (eff_off < OFF_RAM_BASE) begin
			loc = LOC_PERIPH;
		end else if (!eff_bank[0]) begin
			loc = LOC_RAM;
		end else if (eff_off <= OFF_B1_RAM_END) begin
			loc     = LOC_RAM;
			ram_idx = eff_off + B1_RAM_ADD;
		end else if (eff_off >= OFF_MIRROR) begin
			loc = LOC_RAM;
		end
	end

	always_comb begin
		unique case (loc)
			LOC_PC_LOW:   rd_val = pc_r[DATA_W-1:0];
			LOC_FLAGS:    rd_val = flags_r;
			LOC_FPTR:     rd_val = fptr_r;
			LOC_PC_LATCH: rd_val = {{(DATA_W-LATCH_W){1'b0}}, pc_latch_r};
			LOC_RAM:    rd_val = ram[ram_idx];
			default:    rd_val = '0;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pc_r <= RESET_VEC;
		end else if (fetch_ctl_i.irq) begin
			pc_r <= IRQ_VEC;
		end else if (acc_wr && loc == LOC_PC_LOW) begin
			pc_r <= {pc_latch_r, acc.wdata};
		end else if (fetch_ctl_i.jump) begin
			pc_r <= {pc_latch_r[LATCH_W-1:LATCH_W-2], fetch_ctl_i.target};
		end else if (fetch_ctl_i.adv) begin
			pc_r <= pc_r + PC_STEP;
		end
	end

	assign prog_addr_o = pc_r[PROG_AW-1:0];

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			instr_o <= '0;
		end else begin
			instr_o <= prog_mem[pc_r[PROG_AW-1:0]];
		end
	end

	// Program store load port; no reset, contents are software's
	always_ff @(posedge core_clk_i) begin
		if (apb_reg_go && pwrite && paddr == REG_PROG_DATA) begin
			prog_mem[load_addr_r] <= pwdata[INSTR_W-1:0];
		end
	end

	// Load address steps after each word so a block loads without re-addressing
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			load_addr_r <= '0;
		end else if (apb_reg_go && pwrite && paddr == REG_PROG_ADDR) begin
			load_addr_r <= pwdata[PROG_AW-1:0];
		end else if (apb_reg_go && pwrite && paddr == REG_PROG_DATA) begin
			load_addr_r <= load_addr_r + PC_STEP[PROG_AW-1:0];
		end
	end

	// Flags: bits 4:3 are read-only, ALU flags land after any explicit write
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flags_r <= FLAGS_RST;
		end else begin
			if (acc_wr && loc == LOC_FLAGS) begin
				flags_r <= (flags_r & ~FLAGS_WMASK) | (acc.wdata & FLAGS_WMASK);
			end
			if (alu_flags_we_i) begin
				flags_r[FLG_ALU_W-1:0] <= alu_flags_i;
			end
		end
	end

	assign flags_o = flags_r;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fptr_r <= FPTR_RST;
		end else if (acc_wr && loc == LOC_FPTR) begin
			fptr_r <= acc.wdata;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pc_latch_r <= PC_LATCH_RST;
		end else if (acc_wr && loc == LOC_PC_LATCH) begin
			pc_latch_r <= acc.wdata[LATCH_W-1:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (acc_wr && loc == LOC_RAM) begin
			ram[ram_idx] <= acc.wdata;
		end
	end

	// Absent bank hit is sticky; a new hit beats a software clear
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bank_fault_r <= 1'b0;
		end else if (acc_go && bank_absent) begin
			bank_fault_r <= 1'b1;
		end else if (apb_reg_go && pwrite && paddr == REG_FAULT && pwdata[0]) begin
			bank_fault_r <= 1'b0;
		end
	end

	// Operand answer one cycle after the request
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			opr_rsp_o <= '0;
		end else begin
			opr_rsp_o.ack    <= opr_req_i.req;
			opr_rsp_o.periph <= opr_req_i.req && loc == LOC_PERIPH;
			opr_rsp_o.faddr  <= {eff_bank[0], eff_off};
			opr_rsp_o.rdata  <= opr_req_i.req ? rd_val : '0;
		end
	end

	// APB answer: pready rises the cycle after the access is served
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apb_go | apb_reg_go;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (apb_go && !pwrite) begin
				prdata <= {{(APB_DW-DATA_W){1'b0}}, rd_val};
			end else if (apb_reg_go) begin
				unique case (paddr)
					REG_PROG_ADDR: prdata <= {{(APB_DW-PROG_AW){1'b0}}, load_addr_r};
					REG_PROG_DATA: prdata <= pwrite ? '0 :
						{{(APB_DW-INSTR_W){1'b0}}, prog_mem[load_addr_r]};
					REG_PC:        prdata <= {{(APB_DW-PC_W){1'b0}}, pc_r};
					REG_FAULT:     prdata <= {{(APB_DW-1){1'b0}}, bank_fault_r};
					default:       pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule : cmm_decode

// [hw/cmm_pkg.sv]
// Constants, types and carriers for the core memory map and bank decode.
// Assumes one core clock domain; the core fetch and operand logic sit outside.
// Contract
// - Program fetch and data access use separate paths, usable in the same cycle.
// - Program counter is 13 bits wide, spanning 8K words of 14 bits.
// - Only 2K words exist; higher fetch addresses wrap onto them.
// - Every reset starts fetch at program address zero.
// - A taken interrupt sends fetch to program address four.
// - Flags bits 6:5 select the bank; 00 bank 0, 01 bank 1, others absent.
// - Each bank has a 7-bit offset, 128 bytes, top offset 7Fh.
// - Low offsets decode to special registers, higher ones to general RAM except 40h-6Fh in bank 1.
// - Top 16 RAM bytes and core special registers also appear in bank 1.
// - Data file reached directly or indirectly through the file pointer.
// - Upper PC bits load only from the high latch: all on low byte write, bits 4:3 on jump.
package cmm_pkg;

	localparam int PC_W        = 13;
	localparam int PROG_AW     = 11;
	localparam int INSTR_W     = 14;
	localparam int PROG_DEPTH  = 2048;
	localparam int OFF_W       = 7;
	localparam int DATA_W      = 8;
	localparam int RAM_AW      = 7;
	localparam int RAM_DEPTH   = 128;
	localparam int LATCH_W     = 5;
	localparam int APB_AW      = 12;
	localparam int APB_DW      = 32;

	localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VEC   = 13'h0004;
	localparam logic [PC_W-1:0] PC_STEP   = 13'h0001;

	// Offsets inside a bank
	localparam logic [OFF_W-1:0] OFF_INDIRECT  = 7'h00;
	localparam logic [OFF_W-1:0] OFF_PC_LOW    = 7'h02;
	localparam logic [OFF_W-1:0] OFF_FLAGS     = 7'h03;
	localparam logic [OFF_W-1:0] OFF_FPTR      = 7'h04;
	localparam logic [OFF_W-1:0] OFF_PC_LATCH  = 7'h0a;
	localparam logic [OFF_W-1:0] OFF_RAM_BASE  = 7'h20;
	localparam logic [OFF_W-1:0] OFF_B1_RAM_END = 7'h3f;
	localparam logic [OFF_W-1:0] OFF_MIRROR    = 7'h70;
	localparam logic [RAM_AW-1:0] B1_RAM_ADD   = 7'h40;

	// Flags register layout and reset values
	localparam int FLG_BANK_HI = 6;
	localparam int FLG_BANK_LO = 5;
	localparam int FLG_ALU_W   = 3;
	localparam logic [DATA_W-1:0] FLAGS_WMASK = 8'he7;
	localparam logic [DATA_W-1:0] FLAGS_RST   = 8'h18;
	localparam logic [DATA_W-1:0] FPTR_RST     = 8'h00;
	localparam logic [LATCH_W-1:0] PC_LATCH_RST = 5'h00;
	localparam int FPTR_BANK_BIT = 7;

	// APB map: data file at word index = full file address
	localparam int APB_DFILE_BIT = 10;
	localparam int APB_BANK_BIT  = 9;
	localparam logic [APB_AW-1:0] REG_PROG_ADDR = 12'h400;
	localparam logic [APB_AW-1:0] REG_PROG_DATA = 12'h404;
	localparam logic [APB_AW-1:0] REG_PC        = 12'h408;
	localparam logic [APB_AW-1:0] REG_FAULT     = 12'h40c;

	typedef enum logic [2:0] {
		LOC_NONE   = 3'b000,
		LOC_PC_LOW   = 3'b001,
		LOC_FLAGS    = 3'b010,
		LOC_FPTR     = 3'b011,
		LOC_PC_LATCH = 3'b100,
		LOC_RAM    = 3'b101,
		LOC_PERIPH = 3'b110
	} cmm_loc_e;

	typedef struct packed {
		logic                 adv;
		logic                 jump;
		logic                 irq;
		logic [PROG_AW-1:0]   target;
	} cmm_fetch_ctl_s;

	typedef struct packed {
		logic                 req;
		logic                 wr;
		logic [OFF_W-1:0]     addr;
		logic [DATA_W-1:0]    wdata;
	} cmm_opr_req_s;

	typedef struct packed {
		logic                 ack;
		logic                 periph;
		logic [OFF_W:0]       faddr;
		logic [DATA_W-1:0]    rdata;
	} cmm_opr_rsp_s;

	typedef struct packed {
		logic                 wr;
		logic [1:0]           bank;
		logic [OFF_W-1:0]     off;
		logic [DATA_W-1:0]    wdata;
	} cmm_acc_s;

endpackage : cmm_pkg

// [tb/cmm_decode_props.sv]
// Checker for the memory map decode, bound onto its ports.
// Assumes one core clock and the active-low asynchronous reset.
`timescale 1ns/1ps
module cmm_decode_props
	import cmm_pkg::*;
(
	// Clock and reset
	input wire logic                        core_clk_i,
	input wire logic                        rst_b_i,
	// Core side
	input wire cmm_pkg::cmm_fetch_ctl_s     fetch_ctl_i,
	input wire logic [cmm_pkg::PROG_AW-1:0] prog_addr_o,
	input wire cmm_pkg::cmm_opr_req_s       opr_req_i,
	input wire cmm_pkg::cmm_opr_rsp_s       opr_rsp_o,
	input wire logic [cmm_pkg::DATA_W-1:0]  flags_o,
	// APB
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pready
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	ack_follow_a: assert property (opr_req_i.req |=> opr_rsp_o.ack)
		else $error("request without ack");
	ack_idle_a: assert property (!opr_req_i.req |=> !opr_rsp_o.ack)
		else $error("ack without request");
	reset_pc_a: assert property ($rose(rst_b_i) |-> prog_addr_o == 11'h000)
		else $error("fetch not at zero after reset");
	irq_vec_a: assert property (fetch_ctl_i.irq |=> prog_addr_o == 11'h004)
		else $error("interrupt vector wrong");
	// Wrap above 2K words comes from the 11-bit sum
	fetch_step_a: assert property (fetch_ctl_i.adv && !fetch_ctl_i.irq && !fetch_ctl_i.jump
		&& !opr_req_i.wr && !psel |=> prog_addr_o == $past(prog_addr_o) + 11'h001)
		else $error("fetch step wrong");
	jump_tgt_a: assert property (fetch_ctl_i.jump && !fetch_ctl_i.irq && !opr_req_i.wr && !psel
		|=> prog_addr_o == $past(fetch_ctl_i.target))
		else $error("jump target wrong");
	faddr_dir_a: assert property (opr_req_i.req && opr_req_i.addr != 7'h00 && !flags_o[6]
		|=> opr_rsp_o.faddr == {$past(flags_o[5]), $past(opr_req_i.addr)})
		else $error("bank decode wrong");
	periph_zero_a: assert property (opr_rsp_o.ack && opr_rsp_o.periph |-> !opr_rsp_o.rdata)
		else $error("peripheral read not zero");
	apb_ready_a: assert property (psel && penable && !pready && !opr_req_i.req |=> pready)
		else $error("apb answer late");
endmodule : cmm_decode_props

bind cmm_decode cmm_decode_props u_props (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
	.fetch_ctl_i(fetch_ctl_i), .prog_addr_o(prog_addr_o), .opr_req_i(opr_req_i),
	.opr_rsp_o(opr_rsp_o), .flags_o(flags_o), .psel(psel), .penable(penable), .pready(pready));

// [tb/cmm_core_model.sv]
// Core-side model: fetch control and single-byte operand requests.
// Assumes the decode block takes every request at the next edge.
`timescale 1ns/1ps
module cmm_core_model
	import cmm_pkg::*;
(
	// Clock
	input wire logic               core_clk_i,
	// Toward the decode block
	output cmm_pkg::cmm_fetch_ctl_s fetch_ctl_o,
	output cmm_pkg::cmm_opr_req_s   opr_req_o
);
	initial begin
		fetch_ctl_o = '0;
		opr_req_o = '0;
	end
	task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
		@(posedge core_clk_i);
		opr_req_o <= '{req: 1'b1, wr: w, addr: a, wdata: d};
		@(posedge core_clk_i);
		// Released lines show inverted data so stale values are never reused
		opr_req_o <= '{req: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : acc
	task automatic fet(input logic [2:0] c, input logic [10:0] t);
		@(posedge core_clk_i);
		fetch_ctl_o <= {c, t};
		@(posedge core_clk_i);
		fetch_ctl_o <= {3'b000, ~t};
	endtask : fet
endmodule : cmm_core_model

// [tb/tb_cmm_decode.sv]
// Testbench for the memory map decode with a core model and APB master.
// Assumes a 50 MHz core clock; flags from the ALU are left idle.
`timescale 1ns/1ps
module tb_cmm_decode;
	import cmm_pkg::*;
	logic                core_clk_i = 1'b0;
	logic                rst_b_i = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [APB_AW-1:0]   paddr = '0;
	logic [APB_DW-1:0]   pwdata = '0;
	logic [APB_DW-1:0]   prdata;
	logic                pready;
	logic                pslverr;
	cmm_fetch_ctl_s      fetch_ctl;
	cmm_opr_req_s        opr_req;
	cmm_opr_rsp_s        opr_rsp;
	logic [PROG_AW-1:0]  prog_addr;
	logic [INSTR_W-1:0]  instr;
	logic [DATA_W-1:0]   flags;
	logic [8:0]          core_q[$];
	logic [33:0]         apb_q[$];
	logic [8:0]          cq;
	logic [33:0]         aq;
	logic [13:0]         w[5];
	logic [7:0]          d[3];
	int                  bad_count = 0;
	int                  samples_checked = 0;
	int                  seed = 32'h2362;

	always #10 core_clk_i = ~core_clk_i;

	cmm_core_model core (.core_clk_i(core_clk_i), .fetch_ctl_o(fetch_ctl), .opr_req_o(opr_req));
	cmm_decode dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .fetch_ctl_i(fetch_ctl),
		.prog_addr_o(prog_addr), .instr_o(instr), .opr_req_i(opr_req), .alu_flags_we_i(1'b0),
		.alu_flags_i(3'h0), .opr_rsp_o(opr_rsp), .flags_o(flags), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %0t seen %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic finish_test();
		$display("compares %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic cw(input logic [6:0] a, input logic [7:0] v);
		core_q.push_back(9'h000);
		core.acc(1'b1, a, v);
	endtask : cw
	task automatic cr(input logic [6:0] a, input logic [7:0] v);
		core_q.push_back({1'b1, v});
		core.acc(1'b0, a, v);
	endtask : cr
	// Error replies compare pslverr only
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v,
		input logic c, input logic e);
		apb_q.push_back({c, e, v});
		@(posedge core_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge core_clk_i);
		penable <= 1'b1;
		do @(posedge core_clk_i); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	always @(posedge core_clk_i) begin
		if (opr_rsp.ack === 1'b1 && core_q.size() > 0) begin
			cq = core_q.pop_front();
			if (cq[8])
				chk({26'h0, opr_rsp.rdata}, {26'h0, cq[7:0]});
		end
		if (pready === 1'b1 && apb_q.size() > 0) begin
			aq = apb_q.pop_front();
			if (aq[33])
				chk({1'b0, pslverr, aq[32] ? 32'h0 : prdata}, {1'b0, aq[32:0]});
		end
	end

	// Whole run is about 120 cycles; this allows ample margin
	initial begin
		#100us;
		bad_count++;
		finish_test();
	end

	initial begin
		repeat (8) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(negedge core_clk_i);
		chk(flags, FLAGS_RST);
		chk(prog_addr, 0);
		apb(1'b1, REG_PROG_ADDR, 0, 1'b0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			w[i] = 14'($random(seed));
			apb(1'b1, REG_PROG_DATA, {18'h0, w[i]}, 1'b0, 1'b0);
		end
		core.fet(3'b001, 11'h000);
		@(negedge core_clk_i);
		chk(prog_addr, 11'h004);
		@(negedge core_clk_i);
		chk(instr, w[4]);
		core.fet(3'b010, 11'h7ff);
		core.fet(3'b100, 11'h000);
		@(negedge core_clk_i);
		@(negedge core_clk_i);
		chk(instr, w[0]);
		apb(1'b0, REG_PC, 32'h800, 1'b1, 1'b0);
		cw(OFF_PC_LATCH, 8'h1b);
		cw(OFF_PC_LOW, 8'h40);
		apb(1'b0, REG_PC, 32'h1b40, 1'b1, 1'b0);
		core.fet(3'b010, 11'h123);
		apb(1'b0, REG_PC, 32'h1923, 1'b1, 1'b0);
		for (int i = 0; i < 3; i++)
			d[i] = 8'($random(seed));
		cw(7'h25, d[0]);
		cw(7'h7f, d[1]);
		cr(7'h7f, d[1]);
		cw(OFF_FLAGS, 8'h20);
		cr(OFF_FLAGS, 8'h38);
		cw(7'h25, d[2]);
		cw(7'h75, d[1]);
		cw(OFF_FLAGS, 8'h00);
		cr(7'h25, d[0]);
		cr(7'h75, d[1]);
		cw(OFF_FPTR, 8'ha5);
		cr(7'h00, d[2]);
		cw(7'h00, d[0]);
		apb(1'b0, 12'h294, d[0], 1'b1, 1'b0);
		apb(1'b1, 12'h080, d[1], 1'b0, 1'b0);
		cr(7'h20, d[1]);
		cr(7'h01, 8'h00);
		cw(OFF_FLAGS, 8'h40);
		cr(7'h25, 8'h00);
		cw(7'h25, 8'hff);
		cw(OFF_FLAGS, 8'h00);
		cr(7'h25, d[0]);
		apb(1'b0, REG_FAULT, 1, 1'b1, 1'b0);
		apb(1'b0, 12'h410, 0, 1'b1, 1'b1);
		// Mid-run reset: fetch must restart at zero from a nonzero address
		@(posedge core_clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(negedge core_clk_i);
		chk(prog_addr, 0);
		chk(flags, FLAGS_RST);
		repeat (3) @(posedge core_clk_i);
		finish_test();
	end
endmodule : tb_cmm_decode
